/* File: clps_defines.vh */
`ifndef CLPS_DEFINES_VH
`define CLPS_DEFINES_VH
// Register word indices; the byte address is four times the index.
`define CLPS_IDX_CH0_CABLE_LOSS 7'h07
`define CLPS_IDX_CH0_SEG1_AMP 7'h08
`define CLPS_IDX_CH1_CABLE_LOSS 7'h17
`define CLPS_IDX_CH1_SEG1_AMP 7'h18
`define CLPS_IDX_CH2_CABLE_LOSS 7'h27
`define CLPS_IDX_CH2_SEG1_AMP 7'h28
`define CLPS_IDX_CH3_CABLE_LOSS 7'h37
`define CLPS_IDX_CH3_SEG1_AMP 7'h38
`define CLPS_CHAN_STRIDE 7'h10
`define CLPS_CABLE_LOSS_W 6
`define CLPS_SEG_AMP_W 7
`define CLPS_SEG_SIGN_BIT 6
`define CLPS_SEGMENTS 8
`define CLPS_CABLE_LOSS_RST 6'h00
`define CLPS_SEG_AMP_RST 7'h00
`endif

/* File: clps_sync2.v */
// Two-stage synchroniser for the cable-loss estimate arriving from the equalizer.
module clps_sync2 #(
   parameter W = 6
) (
   // Clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // Data
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end
   assign q_o = sync_r;
endmodule

/* File: clps_seg_shaper.v */
`include "clps_defines.vh"
// Per-channel segment sequencer: a one-hot ring splits each master clock period into eight.
module clps_seg_shaper (
   // Clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // Control
   input wire pulse_mode_i,
   input wire seg_tick_i,
   input wire [6:0] seg1_amp_i,
   // Pulse output
   output reg seg1_active_o,
   output reg [6:0] amp_o
);
   reg [7:0] seg_r;
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         seg_r <= 8'h01;
         seg1_active_o <= 1'b0;
         amp_o <= 7'h00;
      end else begin
         if (seg_tick_i)
            seg_r <= {seg_r[6:0], seg_r[7]};
         seg1_active_o <= pulse_mode_i & seg_r[0];
         // Only segment one is owned here; other segments output zero amplitude.
         if (pulse_mode_i && seg_r[0])
            amp_o <= seg1_amp_i;
         else
            amp_o <= 7'h00;
      end
   end
endmodule

/* File: clps_regs.v */
`include "clps_defines.vh"
module clps_regs (
   // Clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [8:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output wire pready_o,
   output reg [31:0] prdata_o,
   output wire pslverr_o,
   // Equalizer cable-loss estimates, one per channel, from the analog side
   input wire [5:0] cable_loss_word_ch0_i,
   input wire [5:0] cable_loss_word_ch1_i,
   input wire [5:0] cable_loss_word_ch2_i,
   input wire [5:0] cable_loss_word_ch3_i,
   // Pulse generator control
   input wire [3:0] pulse_mode_i,
   input wire seg_tick_i,
   output wire [3:0] segment1_active_o,
   output wire [27:0] segment_amp_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Address decode.
   wire [6:0] idx;
   wire setup_rd;
   wire access;
   wire wr_en;
   wire hit_loss_ch0;
   wire hit_loss_ch1;
   wire hit_loss_ch2;
   wire hit_loss_ch3;
   wire hit_amp_ch0;
   wire hit_amp_ch1;
   wire hit_amp_ch2;
   wire hit_amp_ch3;
   wire hit_any;

   assign idx = paddr_i[8:2];
   assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
   assign access = psel_i & penable_i;
   // Lane zero carries the whole register, so a write without it changes nothing.
   assign wr_en = access & pwrite_i & pstrb_i[0];
   // Indices are compared at their own seven-bit width, so no sum is truncated.
   assign hit_loss_ch0 = (idx == `CLPS_IDX_CH0_CABLE_LOSS);
   assign hit_loss_ch1 = (idx == `CLPS_IDX_CH1_CABLE_LOSS);
   assign hit_loss_ch2 = (idx == `CLPS_IDX_CH2_CABLE_LOSS);
   assign hit_loss_ch3 = (idx == `CLPS_IDX_CH3_CABLE_LOSS);
   assign hit_amp_ch0 = (idx == `CLPS_IDX_CH0_SEG1_AMP);
   assign hit_amp_ch1 = (idx == `CLPS_IDX_CH1_SEG1_AMP);
   assign hit_amp_ch2 = (idx == `CLPS_IDX_CH2_SEG1_AMP);
   assign hit_amp_ch3 = (idx == `CLPS_IDX_CH3_SEG1_AMP);
   assign hit_any = hit_loss_ch0 | hit_loss_ch1 |
                    hit_loss_ch2 | hit_loss_ch3 |
                    hit_amp_ch0 | hit_amp_ch1 |
                    hit_amp_ch2 | hit_amp_ch3;

   ////////////////////////////////////////////////////////////////////////////////
   // The equalizer words change on their own timing, so each passes two flip-flops.
   wire [5:0] loss_sync_ch0;
   wire [5:0] loss_sync_ch1;
   wire [5:0] loss_sync_ch2;
   wire [5:0] loss_sync_ch3;

   clps_sync2 #(
      .W(`CLPS_CABLE_LOSS_W)
   ) clps_sync2_ch0 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .d_i(cable_loss_word_ch0_i),
      .q_o(loss_sync_ch0)
   );

   clps_sync2 #(
      .W(`CLPS_CABLE_LOSS_W)
   ) clps_sync2_ch1 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .d_i(cable_loss_word_ch1_i),
      .q_o(loss_sync_ch1)
   );

   clps_sync2 #(
      .W(`CLPS_CABLE_LOSS_W)
   ) clps_sync2_ch2 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .d_i(cable_loss_word_ch2_i),
      .q_o(loss_sync_ch2)
   );

   clps_sync2 #(
      .W(`CLPS_CABLE_LOSS_W)
   ) clps_sync2_ch3 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .d_i(cable_loss_word_ch3_i),
      .q_o(loss_sync_ch3)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Segment-one amplitude, one register per channel so each is set on its own.
   reg [6:0] seg1_amp_ch0_r;
   reg [6:0] seg1_amp_ch1_r;
   reg [6:0] seg1_amp_ch2_r;
   reg [6:0] seg1_amp_ch3_r;

   // Writes to bit 7 are dropped since only seven bits are stored.
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         seg1_amp_ch0_r <= `CLPS_SEG_AMP_RST;
      end else if (wr_en && hit_amp_ch0) begin
         seg1_amp_ch0_r <= pwdata_i[6:0];
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         seg1_amp_ch1_r <= `CLPS_SEG_AMP_RST;
      end else if (wr_en && hit_amp_ch1) begin
         seg1_amp_ch1_r <= pwdata_i[6:0];
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         seg1_amp_ch2_r <= `CLPS_SEG_AMP_RST;
      end else if (wr_en && hit_amp_ch2) begin
         seg1_amp_ch2_r <= pwdata_i[6:0];
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         seg1_amp_ch3_r <= `CLPS_SEG_AMP_RST;
      end else if (wr_en && hit_amp_ch3) begin
         seg1_amp_ch3_r <= pwdata_i[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read words; reserved bits are tied to zero so no write can reach them.
   wire [31:0] rd_loss_ch0;
   wire [31:0] rd_loss_ch1;
   wire [31:0] rd_loss_ch2;
   wire [31:0] rd_loss_ch3;
   wire [31:0] rd_amp_ch0;
   wire [31:0] rd_amp_ch1;
   wire [31:0] rd_amp_ch2;
   wire [31:0] rd_amp_ch3;
   reg [31:0] rdata_nxt;

   // Bit 5 of the word stays the most significant, as the equalizer delivers it.
   assign rd_loss_ch0 = {26'h0000000, loss_sync_ch0};
   assign rd_loss_ch1 = {26'h0000000, loss_sync_ch1};
   assign rd_loss_ch2 = {26'h0000000, loss_sync_ch2};
   assign rd_loss_ch3 = {26'h0000000, loss_sync_ch3};
   assign rd_amp_ch0 = {25'h0000000, seg1_amp_ch0_r};
   assign rd_amp_ch1 = {25'h0000000, seg1_amp_ch1_r};
   assign rd_amp_ch2 = {25'h0000000, seg1_amp_ch2_r};
   assign rd_amp_ch3 = {25'h0000000, seg1_amp_ch3_r};

   always @* begin
      rdata_nxt = 32'h00000000;
      case (idx)
         `CLPS_IDX_CH0_CABLE_LOSS: begin
            rdata_nxt = rd_loss_ch0;
         end
         `CLPS_IDX_CH1_CABLE_LOSS: begin
            rdata_nxt = rd_loss_ch1;
         end
         `CLPS_IDX_CH2_CABLE_LOSS: begin
            rdata_nxt = rd_loss_ch2;
         end
         `CLPS_IDX_CH3_CABLE_LOSS: begin
            rdata_nxt = rd_loss_ch3;
         end
         `CLPS_IDX_CH0_SEG1_AMP: begin
            rdata_nxt = rd_amp_ch0;
         end
         `CLPS_IDX_CH1_SEG1_AMP: begin
            rdata_nxt = rd_amp_ch1;
         end
         `CLPS_IDX_CH2_SEG1_AMP: begin
            rdata_nxt = rd_amp_ch2;
         end
         `CLPS_IDX_CH3_SEG1_AMP: begin
            rdata_nxt = rd_amp_ch3;
         end
         default: begin
            rdata_nxt = 32'h00000000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Zero-wait slave; unmapped addresses read zero and return an error.
   assign pready_o = 1'b1;
   assign pslverr_o = access & ~hit_any;

   // Read data is captured in the setup cycle, so it stands through the access phase.
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         prdata_o <= 32'h00000000;
      end else if (setup_rd) begin
         prdata_o <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One segment sequencer per channel; they share the tick but not the mode.
   wire [6:0] amp_ch0;
   wire [6:0] amp_ch1;
   wire [6:0] amp_ch2;
   wire [6:0] amp_ch3;

   clps_seg_shaper clps_seg_shaper_ch0 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pulse_mode_i(pulse_mode_i[0]),
      .seg_tick_i(seg_tick_i),
      .seg1_amp_i(seg1_amp_ch0_r),
      .seg1_active_o(segment1_active_o[0]),
      .amp_o(amp_ch0)
   );

   clps_seg_shaper clps_seg_shaper_ch1 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pulse_mode_i(pulse_mode_i[1]),
      .seg_tick_i(seg_tick_i),
      .seg1_amp_i(seg1_amp_ch1_r),
      .seg1_active_o(segment1_active_o[1]),
      .amp_o(amp_ch1)
   );

   clps_seg_shaper clps_seg_shaper_ch2 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pulse_mode_i(pulse_mode_i[2]),
      .seg_tick_i(seg_tick_i),
      .seg1_amp_i(seg1_amp_ch2_r),
      .seg1_active_o(segment1_active_o[2]),
      .amp_o(amp_ch2)
   );

   clps_seg_shaper clps_seg_shaper_ch3 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pulse_mode_i(pulse_mode_i[3]),
      .seg_tick_i(seg_tick_i),
      .seg1_amp_i(seg1_amp_ch3_r),
      .seg1_active_o(segment1_active_o[3]),
      .amp_o(amp_ch3)
   );

   // Channel zero sits in the low seven bits of the amplitude bus.
   assign segment_amp_o = {amp_ch3, amp_ch2, amp_ch1, amp_ch0};
endmodule

/* File: clps_regs_chk.sv */
module clps_regs_chk (
   // Clock, reset and bus
   input logic core_clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
   input logic [8:0] paddr_i,
   input logic [31:0] prdata_o,
   // Channel signals
   input logic [5:0] cable_loss_word_ch0_i,
   input logic [3:0] pulse_mode_i, segment1_active_o,
   input logic [27:0] segment_amp_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   sequence acc(logic [5:0] lo);
      psel_i && penable_i && !pwrite_i && !paddr_i[8] && paddr_i[5:0] == lo;
   endsequence
   sequence rd_setup;
      psel_i && !penable_i && !pwrite_i && paddr_i == 9'h01C;
   endsequence
   ////////////////////////////////
   cl_read_a: assert property (rd_setup ##0 $stable(cable_loss_word_ch0_i) &&
      cable_loss_word_ch0_i == $past(cable_loss_word_ch0_i, 2)
      |=> prdata_o[5:0] == $past(cable_loss_word_ch0_i)) else $error("cable loss read");
   cl_resv_a: assert property (acc(6'h1C) |-> prdata_o[31:6] == 26'h0) else $error("resv");
   cl_ok_a: assert property (acc(6'h1C) |-> pready_o && !pslverr_o) else $error("cl");
   amp_resv_a: assert property (acc(6'h20) |-> prdata_o[31:7] == 25'h0 && !pslverr_o)
      else $error("amp read");
   bad_addr_a: assert property (psel_i && penable_i && paddr_i == 9'h004 |-> pslverr_o)
      else $error("unmapped");
   mode_off_a: assert property (!pulse_mode_i[3] ##1 !pulse_mode_i[3] |-> !segment1_active_o[3])
      else $error("mode off");
   amp_idle_a: assert property (!segment1_active_o[0] |-> segment_amp_o[6:0] == 7'h00)
      else $error("idle amp");
   seg_gap_a: assert property ($fell(segment1_active_o[2]) && $past(pulse_mode_i[2])
      |-> !segment1_active_o[2] [*7]) else $error("segment gap");
endmodule
bind clps_regs clps_regs_chk clps_regs_chk_inst (.*);

/* File: clps_regs_test.sv */
module clps_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, seg_tick_i = 0, e;
   logic [8:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, q, r = 32'h5981;
   logic [3:0] pstrb_i = 0, pulse_mode_i = 0;
   logic [5:0] cl [4] = '{default: 0};
   logic [6:0] amp [4] = '{default: 0};
   wire pready_o, pslverr_o;
   wire [31:0] prdata_o;
   wire [3:0] segment1_active_o;
   wire [27:0] segment_amp_o;
   int num_errors, total_checks, n, m;
   always #10 core_clk_i = ~core_clk_i;
   clps_regs clps_regs_inst (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
      .cable_loss_word_ch0_i(cl[0]), .cable_loss_word_ch1_i(cl[1]),
      .cable_loss_word_ch2_i(cl[2]), .cable_loss_word_ch3_i(cl[3]),
      .pulse_mode_i(pulse_mode_i), .seg_tick_i(seg_tick_i),
      .segment1_active_o(segment1_active_o), .segment_amp_o(segment_amp_o));
   ////////////////////////////////
   function logic [31:0] lfsr(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function logic [8:0] ad(int c, int k);
      return 9'((c * 16 + k) * 4);
   endfunction
   task chk(string s, logic [31:0] x, logic [31:0] g);
      total_checks++;
      if (g !== x) begin
         num_errors++;
         $display("unexpected %s exp %h got %h", s, x, g);
      end
   endtask
   task apb(logic w, logic [8:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
      @(posedge core_clk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} <= {2'h2, w, a, d, s};
      @(posedge core_clk_i);
      penable_i <= 1'h1;
      do @(posedge core_clk_i); while (pready_o !== 1'h1);
      q = prdata_o;
      e = pslverr_o;
      {psel_i, penable_i} <= 2'h0;
   endtask
   task complete_run;
      if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk_i);
      num_errors++;
      complete_run;
   end
   initial begin
      repeat (20) @(posedge core_clk_i);
      resetn_i <= 1'h1;
      for (int c = 0; c < 4; c++) begin
         apb(1'h0, ad(c, 7), 32'h0);
         chk("cable_loss", 32'h0, q);
         apb(1'h0, ad(c, 8), 32'h0);
         chk("seg1_amp", 32'h0, q);
      end
      for (int i = 0; i < 24; i++) begin
         r = lfsr(r);
         n = i % 4;
         m = (n + 1) % 4;
         cl[n] <= r[5:0];
         apb(1'h1, ad(n, 7), r);
         apb(1'h1, ad(n, 8), r, {3'h7, r[9]});
         if (r[9]) amp[n] = r[6:0];
         apb(1'h0, ad(n, 7), 32'h0);
         chk("cable_loss", {26'h0, r[5:0]}, q);
         apb(1'h0, ad(n, 8), 32'h0);
         chk("seg1_amp", {25'h0, amp[n]}, q);
         apb(1'h0, ad(m, 8), 32'h0);
         chk("seg1_amp", {25'h0, amp[m]}, q);
      end
      apb(1'h1, 9'h004, r);
      apb(1'h0, 9'h004, 32'h0);
      chk("unmapped", 32'h0, q);
      chk("slverr", 32'h1, e);
      pulse_mode_i <= 4'h7;
      seg_tick_i <= 1'h1;
      repeat (4) @(posedge core_clk_i);
      n = 0;
      m = 0;
      repeat (64) begin
         @(negedge core_clk_i);
         n += segment1_active_o[0];
         m += segment1_active_o[3];
         for (int c = 0; c < 4; c++)
            chk("seg_amp", segment1_active_o[c] ? amp[c] : 7'h00, segment_amp_o[c*7+:7]);
      end
      chk("seg1_count", 32'h8, n);
      chk("seg1_off", 32'h0, m);
      complete_run;
   end
endmodule
